// ===== logic/measure_timer.sv
// three channel timer / event counter / pulse measurement with AXI4-Lite registers
//
// Function
// R1: three channels, own mode, counter, shared run bits
// R2: idle after reset, counts after run bit set
// R3: software changes mode only while stopped
// R4: live count read, all ones on reload
// R5: read before start returns written value
// R6: measurement irq on edge or overflow
// R7: readable overflow flag in mode register
// R8: clear flag by rewrite with aux two zero
// R9: clear needs running and tick after set
// R10: first edge loads reload, no irq
// R11: counter undefined at start, early overflow possible
// R12: width mode measures both levels back to back
// R13: software uses irq for overflow detection only
// R14: simultaneous edge and overflow need another timer
// R15: timer/event decrement, reload on underflow, irq
`timescale 1ns/1ps

module measure_timer
    import mtimer_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NCH-1:0] ext_pulse,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    typedef struct packed {
        logic [NCH-1:0] run;
        logic [NCH-1:0][7:0] mode;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        logic [NCH-1:0][CNT_W-1:0] rld;
        logic [NCH-1:0] prev;
        logic [NCH-1:0] first;
        logic [NCH-1:0] ovf_tick;
        logic [7:0] presc;
        logic [NCH-1:0] status;
        logic [NCH-1:0] mask;
        logic irq;
        logic aw_held;
        logic [ADDR_W-1:0] waddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s s;
    state_s n;
    logic [NCH-1:0] tick;
    logic [NCH-1:0] eff;
    logic [NCH-1:0] reloaded;
    logic [NCH-1:0] ev_set;
    logic [NCH-1:0] ovf_hw;
    logic [NCH-1:0] clr;
    logic [31:0] wd;
    logic wr_fire;
    logic rd_fire;

    // channel register address, sel 0 mode, 1 counter
    function automatic logic [7:0] ch_ofs(input int ch, input logic sel);
        logic [7:0] o;
        o = OFS_CH_BASE + 8'(ch) * CH_STRIDE;
        return sel ? o + OFS_CNT_REL : o;
    endfunction

    function automatic logic src_tick(input logic [1:0] src, input logic [7:0] p);
        case (src)
            2'b00: return 1'b1;
            2'b01: return (p & PRE_DIV8) == 8'h00;
            2'b10: return (p & PRE_DIV32) == 8'h00;
            default: return (p & PRE_DIV256) == 8'h00;
        endcase
    endfunction

    // aux0 picks rising or falling; width mode (aux1) takes both edges
    function automatic logic edge_hit(input logic [7:0] m, input logic cur, input logic prv);
        logic rise;
        logic fall;
        rise = cur & ~prv;
        fall = ~cur & prv;
        if (m[MB_OP+:2] == OP_MEASURE && m[MB_AUX1]) begin
            return rise | fall;
        end
        return m[MB_AUX0] ? fall : rise;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8+:8] = d[b*8+:8];
            end
        end
        return r;
    endfunction

    always_comb begin
        n = s;
        tick = '0;
        eff = '0;
        reloaded = '0;
        ev_set = '0;
        ovf_hw = '0;
        clr = '0;
        wd = 32'h0000_0000;
        wr_fire = s.aw_held && s.w_held && !s.bvalid;
        rd_fire = s_axi_arvalid && s.arready;
        n.presc = s.presc + 8'h01;

        // channel counting
        for (int i = 0; i < NCH; i++) begin
            tick[i] = src_tick(s.mode[i][MB_SRC+:2], s.presc);
            eff[i] = edge_hit(s.mode[i], ext_pulse[i], s.prev[i]);
            n.prev[i] = ext_pulse[i];
            if (s.run[i]) begin // R2
                if (s.mode[i][MB_OP+:2] == OP_MEASURE) begin
                    // counter free runs from whatever it holds R11
                    if (tick[i]) begin
                        n.cnt[i] = s.cnt[i] + 16'h0001;
                        n.ovf_tick[i] = 1'b1; // R9
                        if (s.cnt[i] == CNT_ALL_ONES) begin
                            n.mode[i][MB_OVF] = 1'b1; // R7
                            n.ovf_tick[i] = 1'b0;
                            ovf_hw[i] = 1'b1;
                            ev_set[i] = 1'b1; // R6
                        end
                    end
                    if (eff[i]) begin
                        n.rld[i] = s.cnt[i]; // R10
                        n.cnt[i] = CNT_RST; // R12
                        n.first[i] = 1'b1;
                        if (s.first[i]) begin
                            ev_set[i] = 1'b1; // R6
                        end
                    end
                end else if ((s.mode[i][MB_OP+:2] == OP_EVENT) ? eff[i] : tick[i]) begin
                    if (s.cnt[i] == CNT_RST) begin
                        n.cnt[i] = s.rld[i]; // R15
                        reloaded[i] = 1'b1;
                        ev_set[i] = 1'b1; // R15
                    end else begin
                        n.cnt[i] = s.cnt[i] - 16'h0001; // R15
                    end
                end
            end
        end

        // register writes
        if (s_axi_awvalid && s.awready) begin
            n.aw_held = 1'b1;
            n.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_held = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_fire) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            if (s.waddr == OFS_RUN) begin
                wd = merge({29'h0, s.run}, s.wdata, s.wstrb);
                n.first = n.first & ~(wd[2:0] & ~s.run);
                n.run = wd[2:0]; // R1
            end else if (s.waddr == OFS_IRQ_STAT) begin
                wd = merge(32'h0000_0000, s.wdata, s.wstrb);
                clr = wd[2:0];
            end else if (s.waddr == OFS_IRQ_MASK) begin
                wd = merge({29'h0, s.mask}, s.wdata, s.wstrb);
                n.mask = wd[2:0];
            end else begin
                n.bresp = RESP_SLVERR;
                for (int i = 0; i < NCH; i++) begin
                    if (s.waddr == ch_ofs(i, 1'b0)) begin
                        n.bresp = RESP_OKAY;
                        wd = merge({24'h0, s.mode[i]}, s.wdata, s.wstrb);
                        if (!s.run[i]) begin
                            n.mode[i] = (wd[7:0] & ~OVF_MASK) | (n.mode[i] & OVF_MASK); // R3
                        end else if (!wd[MB_AUX2] && s.ovf_tick[i] && !ovf_hw[i]) begin
                            n.mode[i][MB_OVF] = 1'b0; // R8 R9
                        end
                    end else if (s.waddr == ch_ofs(i, 1'b1)) begin
                        n.bresp = RESP_OKAY;
                        wd = merge({16'h0, s.rld[i]}, s.wdata, s.wstrb);
                        n.rld[i] = wd[15:0];
                        if (!s.run[i]) begin
                            n.cnt[i] = wd[15:0]; // R5
                        end
                    end
                end
            end
        end
        n.awready = !n.aw_held && !n.bvalid;
        n.wready = !n.w_held && !n.bvalid;

        // set wins over a write-one clear
        n.status = (s.status & ~clr) | ev_set;
        n.irq = |(n.status & n.mask);

        // register reads
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (rd_fire) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0000_0000;
            if (s_axi_araddr == OFS_RUN) begin
                n.rdata[2:0] = s.run;
            end else if (s_axi_araddr == OFS_IRQ_STAT) begin
                n.rdata[2:0] = s.status;
            end else if (s_axi_araddr == OFS_IRQ_MASK) begin
                n.rdata[2:0] = s.mask;
            end else begin
                n.rresp = RESP_SLVERR;
                for (int i = 0; i < NCH; i++) begin
                    if (s_axi_araddr == ch_ofs(i, 1'b0)) begin
                        n.rresp = RESP_OKAY;
                        n.rdata[7:0] = s.mode[i]; // R7
                    end else if (s_axi_araddr == ch_ofs(i, 1'b1)) begin
                        n.rresp = RESP_OKAY;
                        if (s.mode[i][MB_OP+:2] == OP_MEASURE) begin
                            n.rdata[15:0] = s.rld[i];
                        end else if (reloaded[i]) begin
                            n.rdata[15:0] = CNT_ALL_ONES; // R4
                        end else begin
                            n.rdata[15:0] = s.cnt[i]; // R4 R5
                        end
                    end
                end
            end
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign irq = s.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_idle_holds_count: assert property ( // R2
        !s.run[0] && !wr_fire |=> $stable(s.cnt[0]))
        else $error("stopped channel counter changed");

    a_reload_reads_ones: assert property ( // R4
        rd_fire && s_axi_araddr == ch_ofs(1, 1'b1) && reloaded[1]
        |=> s.rvalid && s.rdata == 32'h0000_FFFF)
        else $error("read at reload did not return all ones");

    a_preload_read_back: assert property ( // R5
        wr_fire && s.waddr == ch_ofs(0, 1'b1) && !s.run[0] && s.wstrb == 4'hF
        |=> s.cnt[0] == $past(s.wdata[15:0]))
        else $error("written count not held before start");

    a_measure_edge_irq: assert property ( // R6
        s.run[2] && s.mode[2][1:0] == OP_MEASURE && eff[2] && s.first[2]
        |=> s.status[2] ##1 (irq || !(s.status[2] && s.mask[2])))
        else $error("measurement edge did not raise request");

    a_overflow_flag_set: assert property ( // R7
        s.run[2] && s.mode[2][1:0] == OP_MEASURE && tick[2] && s.cnt[2] == 16'hFFFF
        |=> s.mode[2][MB_OVF] && s.status[2] && s.cnt[2] == 16'h0000)
        else $error("overflow did not set flag");

    a_ovf_clear_guard: assert property ( // R9
        s.mode[2][MB_OVF] && !s.ovf_tick[2] |=> s.mode[2][MB_OVF])
        else $error("overflow flag cleared without a tick");

    a_first_edge_quiet: assert property ( // R10
        s.run[2] && s.mode[2][1:0] == OP_MEASURE && eff[2] && !s.first[2]
        && !ovf_hw[2] && !wr_fire
        |=> s.status[2] == $past(s.status[2]) && s.rld[2] == $past(s.cnt[2]))
        else $error("first edge raised a request");

    a_width_both_edges: assert property ( // R12
        s.run[2] && s.mode[2][1:0] == OP_MEASURE && s.mode[2][MB_AUX1]
        && ext_pulse[2] != s.prev[2] && !wr_fire
        |=> s.first[2] && s.cnt[2] == 16'h0000)
        else $error("width mode missed an edge");

    a_underflow_reload: assert property ( // R15
        s.run[1] && s.mode[1][1:0] == OP_TIMER && tick[1] && s.cnt[1] == 16'h0000
        && !wr_fire
        |=> s.cnt[1] == $past(s.rld[1]) && s.status[1])
        else $error("underflow did not reload");

endmodule

// ===== logic/mtimer_pkg.sv
// constants shared by the three channel measure timer
package mtimer_pkg;
    localparam int NCH = 3;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;

    // register byte offsets
    localparam logic [7:0] OFS_RUN = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_CH_BASE = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h08;
    localparam logic [7:0] OFS_CNT_REL = 8'h04;

    // mode register fields
    localparam int MB_OP = 0;
    localparam int MB_AUX0 = 2;
    localparam int MB_AUX1 = 3;
    localparam int MB_AUX2 = 4;
    localparam int MB_OVF = 5;
    localparam int MB_SRC = 6;
    localparam logic [7:0] OVF_MASK = 8'h20;

    typedef enum logic [1:0] {
        OP_TIMER = 2'b00,
        OP_EVENT = 2'b01,
        OP_MEASURE = 2'b10
    } op_e;

    // count source prescaler taps
    localparam logic [7:0] PRE_DIV8 = 8'h07;
    localparam logic [7:0] PRE_DIV32 = 8'h1F;
    localparam logic [7:0] PRE_DIV256 = 8'hFF;

    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0] MODE_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== tb/pulse_source.sv
// partner model: one square wave pulse source per channel
`timescale 1ns/1ps
module pulse_source
    import mtimer_pkg::*;
#(
    parameter int HALF = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NCH-1:0] en,
    output logic [NCH-1:0] pulse
);
    int cnt [NCH];

    // idle level is low while a channel source is disabled
    always @(posedge clk or negedge nrst) begin
        for (int i = 0; i < NCH; i++) begin
            if (!nrst || !en[i]) begin
                cnt[i] <= 0;
                pulse[i] <= 1'b0;
            end else if (cnt[i] == HALF - 1) begin
                cnt[i] <= 0;
                pulse[i] <= ~pulse[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule

// ===== tb/tb_three_channel_measure_timer.sv
// self-checking testbench for the three channel measure timer
`timescale 1ns/1ps
module tb_three_channel_measure_timer
    import mtimer_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [NCH-1:0] pen = '0;
    logic [NCH-1:0] ext_pulse;
    logic [7:0] s_axi_awaddr = '0;
    logic [7:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h267C4117;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] rel;
    logic [15:0] d0;
    int ones = 0;

    always #4 clk = ~clk;

    measure_timer dut (.clk, .nrst, .ext_pulse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

    pulse_source #(.HALF(20)) src (.clk, .nrst, .en(pen), .pulse(ext_pulse));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] mode_at(input int i);
        return OFS_CH_BASE + CH_STRIDE * 8'(i);
    endfunction

    function automatic logic [7:0] cnt_at(input int i);
        return mode_at(i) + OFS_CNT_REL;
    endfunction

    // count source ticks over span clocks for a source select
    function automatic logic [31:0] ticks_in(input int sel, input int span);
        logic [31:0] div;
        if (sel == 1) begin
            div = {24'h0, PRE_DIV8};
        end else if (sel == 2) begin
            div = {24'h0, PRE_DIV32};
        end else begin
            div = {24'h0, PRE_DIV256};
        end
        return 32'(span) / (div + 32'h1);
    endfunction

    // captured count within two cycles of the nominal figure
    function automatic logic [31:0] near(input logic [31:0] v, input logic [31:0] c);
        return {31'h0, (v + 32'h2 >= c) && (v <= c + 32'h2)};
    endfunction

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aon;
        logic won;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aon = 1'b1;
        won = 1'b1;
        do begin
            @(posedge clk);
            if (aon && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aon = 1'b0;
            end
            if (won && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                won = 1'b0;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic aon;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        aon = 1'b1;
        do begin
            @(posedge clk);
            if (aon && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                aon = 1'b0;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict;
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        cyc(2);
        rd(OFS_RUN);
        chk(d, 32'h0);
        for (int i = 0; i < NCH; i++) begin
            rd(mode_at(i));
            chk(d, 32'h0);
            rd(cnt_at(i));
            chk(d, 32'h0);
        end
        rd(8'h0C);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h0C, 32'h1);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        seed = lfsr(seed);
        wr(cnt_at(2), {16'h0, seed[15:0]});
        rd(cnt_at(2));
        chk(d, {16'h0, seed[15:0]});
        // low byte lane only
        s_axi_wstrb <= 4'h1;
        wr(cnt_at(2), 32'h0000_ABCD);
        s_axi_wstrb <= 4'hF;
        rd(cnt_at(2));
        chk(d, {16'h0, seed[15:8], 8'hCD});
        // channel 0 counts events, channel 1 times the clock
        seed = lfsr(seed);
        rel = 16'h0004 + {13'h0, seed[2:0]};
        wr(mode_at(0), 32'h1);
        wr(cnt_at(0), 32'h2);
        wr(mode_at(1), 32'h0);
        wr(cnt_at(1), {16'h0, rel});
        wr(OFS_RUN, 32'h3);
        pen <= 3'b001;
        @(posedge ext_pulse[0]);
        cyc(3);
        rd(OFS_IRQ_STAT);
        chk({30'h0, d[1:0]}, 32'h2);
        // read spacing one more than the reload period walks every phase once
        for (int j = 0; j <= int'(rel); j++) begin
            rd(cnt_at(1));
            chk({31'h0, d[15:0] <= rel || d[15:0] == 16'hFFFF}, 32'h1);
            ones += int'(d[15:0] == 16'hFFFF);
            cyc(int'(rel) - 1);
        end
        chk(ones, 32'h1);
        repeat (3) @(posedge ext_pulse[0]);
        cyc(3);
        rd(OFS_IRQ_STAT);
        chk({31'h0, d[0]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h3);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_RUN, 32'h0);
        pen <= 3'b000;
        wr(OFS_IRQ_STAT, 32'h3);
        rd(OFS_IRQ_STAT);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // channel 0 counts falling edges only
        wr(mode_at(0), 32'h5);
        wr(cnt_at(0), 32'h10);
        wr(OFS_RUN, 32'h1);
        pen <= 3'b001;
        @(posedge ext_pulse[0]);
        cyc(3);
        rd(cnt_at(0));
        chk(d, 32'h10);
        @(negedge ext_pulse[0]);
        cyc(3);
        rd(cnt_at(0));
        chk(d, 32'hF);
        pen <= 3'b000;
        // channel 1 on each divided count source
        for (int k = 1; k < 4; k++) begin
            wr(OFS_RUN, 32'h0);
            wr(mode_at(1), {24'h0, 2'(k), 6'h00});
            wr(cnt_at(1), 32'h0100);
            wr(OFS_RUN, 32'h2);
            rd(cnt_at(1));
            d0 = d[15:0];
            cyc(253);
            rd(cnt_at(1));
            chk({16'h0, d0 - d[15:0]}, ticks_in(k, 256));
        end
        // channel 2 overflows from near the top, then measures periods
        wr(cnt_at(2), 32'hFFF0);
        wr(mode_at(2), 32'h12);
        wr(OFS_IRQ_MASK, 32'h4);
        wr(OFS_RUN, 32'h4);
        cyc(30);
        rd(mode_at(2));
        chk({31'h0, d[MB_OVF]}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(mode_at(2), 32'h02);
        rd(mode_at(2));
        chk({31'h0, d[MB_OVF]}, 32'h0);
        wr(OFS_IRQ_STAT, 32'h4);
        // counter restarts low, so edges stay clear of overflows
        pen <= 3'b100;
        @(posedge ext_pulse[2]);
        cyc(4);
        rd(OFS_IRQ_STAT);
        chk({31'h0, d[2]}, 32'h0);
        @(posedge ext_pulse[2]);
        cyc(4);
        rd(OFS_IRQ_STAT);
        chk({31'h0, d[2]}, 32'h1);
        rd(cnt_at(2));
        chk(near(d, 32'd40), 32'h1);
        // width measurement sees both levels in turn
        wr(OFS_RUN, 32'h0);
        pen <= 3'b000;
        wr(mode_at(2), 32'h0A);
        wr(OFS_RUN, 32'h4);
        pen <= 3'b100;
        repeat (3) @(ext_pulse[2]);
        cyc(4);
        rd(cnt_at(2));
        chk(near(d, 32'd20), 32'h1);
        print_verdict;
    end
endmodule
